// File: core/pmrcp_defines.svh
// Constants for the controller-side port of one PHY channel.
// Assumes inclusion by bare name from core and bench files.
`ifndef PMRCP_DEFINES_SVH
`define PMRCP_DEFINES_SVH

// ==========================================
// Receive buffer shape
`define PMRCP_FIFO_DEPTH 4
`define PMRCP_FIFO_WIDTH 6
`define PMRCP_FIFO_ERR_BIT 5
`define PMRCP_FIFO_FIFTH_BIT 4

// ==========================================
// Line symbols
`define PMRCP_TX_ERR_SYM 5'h04
`define PMRCP_RMII_DATA_MASK 4'h3

// ==========================================
// Management frame
`define PMRCP_PREAMBLE_LEN 6'h20
`define PMRCP_OP_READ 2'h2
`define PMRCP_FIELD_LEN 6'h05
`define PMRCP_OP_LEN 6'h02
`define PMRCP_DATA_LEN 6'h10
`define PMRCP_IRQ_REG_ADDR 5'h11
`define PMRCP_CHAN_RESET 2'h0

`endif

// File: core/pmrcp_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
// Assumes both sides run on mclk with a synchronous active-high reset.
`timescale 1ns/1ns
module pmrcp_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 4
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic do_wr, do_rd;

  // ==========================================
  // Pointer and count update
  always_comb begin
    in_ready = (count != (AW+1)'(DEPTH));
    out_valid = (count != '0);
    do_wr = in_valid && in_ready;
    do_rd = out_valid && out_ready;
    next_wr_ptr = do_wr ? AW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = do_rd ? AW'(rd_ptr + 1'b1) : rd_ptr;
    next_count = count;
    if (do_wr && !do_rd) begin
      next_count = (AW+1)'(count + 1'b1);
    end else if (do_rd && !do_wr) begin
      next_count = (AW+1)'(count - 1'b1);
    end
    out_data = mem[rd_ptr];
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

// File: core/pmrcp_pkg.sv
// Types shared by the controller-side port of one PHY channel.
// Assumes nothing of its surroundings.
package pmrcp_pkg;

  // ==========================================
  // Management frame states
  typedef enum logic [2:0] {
    M_IDLE  = 3'b000,
    M_START = 3'b001,
    M_OP    = 3'b010,
    M_PHY   = 3'b011,
    M_REG   = 3'b100,
    M_TA    = 3'b101,
    M_DATA  = 3'b110
  } pmrcp_mstate_t;

endpackage

// File: core/pmrcp_port.sv
// Controller-side MII/RMII port of one PHY channel, with its management
// interrupt and address match.
// Assumes line-side logic on mclk; pins and the reference clock are asynchronous.
// How it works
// - Transmit inputs are taken on rising transmit clock edges only.
// - Transmit data and error are ignored while transmit enable is low.
// - MII takes four transmit bits; RMII takes only the two low bits.
// - Transmit error with enable high sends the error symbol on the line in MII without encoder bypass.
// - Encoder bypass makes transmit error the fifth data bit; unused in RMII.
// - Receive outputs change only on falling receive clock edges.
// - Carrier sense follows line carrier, updated on falling receive clock.
// - Receive data valid marks decoded nibbles; held low in RMII.
// - MII gives four receive bits; RMII gives only the two low bits.
// - Receive error shows line coding errors, updated on falling receive clock.
// - Decoder bypass puts the fifth received bit on the error output; unused in RMII.
// - Collision is high while transmit and receive activity coincide.
// - Management data is shifted in and out on management clock rises.
// - Interrupt pulls low when a monitored bit changes value.
// - Interrupt releases only after every changed bit is read out.
// - Interface select high picks RMII, low picks MII.
`timescale 1ns/1ns
`include "pmrcp_defines.svh"
module pmrcp_port #(
  parameter logic [1:0] CHAN = `PMRCP_CHAN_RESET
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ref_clk_in,
  input wire logic rmii_sel,
  input wire logic bypass_enc,
  input wire logic bypass_dec,
  output logic tx_clk,
  input wire logic tx_en,
  input wire logic [3:0] txd,
  input wire logic tx_er,
  output logic rx_clk,
  output logic [3:0] rxd,
  output logic rx_dv,
  output logic rx_er,
  output logic crs,
  output logic col,
  output logic [4:0] line_tx_data,
  output logic line_tx_valid,
  output logic line_tx_err,
  input wire logic line_rx_valid,
  output logic line_rx_ready,
  input wire logic [3:0] line_rx_data,
  input wire logic line_rx_fifth,
  input wire logic line_rx_code_err,
  input wire logic line_rx_carrier,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [2:0] phy_addr_strap_hi,
  input wire logic [15:0] monitor_bits,
  output logic mgmt_irq_n,
  output logic mgmt_irq_oe
);

  // ==========================================
  // Pin synchronisers
  localparam int SW = 13;
  logic [SW-1:0] sync1, sync2, next_sync1, next_sync2;
  logic ref_s, tx_en_s, tx_er_s, rmii_s, mdc_s, mdio_s;
  logic [3:0] txd_s;
  logic [2:0] strap_s;

  always_comb begin
    next_sync1 = {ref_clk_in, tx_en, txd, tx_er, rmii_sel, mdc, mdio_in, phy_addr_strap_hi};
    next_sync2 = sync1;
    {ref_s, tx_en_s, txd_s, tx_er_s, rmii_s, mdc_s, mdio_s, strap_s} = sync2;
  end

  // Not reset, so the straps are settled when reset captures the address
  always_ff @(posedge mclk) begin
    sync1 <= next_sync1;
    sync2 <= next_sync2;
  end

  // ==========================================
  // Clock outputs and edge detect
  logic clk_q, next_clk_q, tx_rise, rx_fall;

  always_comb begin
    next_clk_q = ref_s;
    tx_rise = ref_s && !clk_q;
    rx_fall = !ref_s && clk_q;
    tx_clk = clk_q;
    rx_clk = clk_q;
  end

  // ==========================================
  // Transmit path
  logic [4:0] next_line_tx_data;
  logic next_line_tx_valid, next_line_tx_err;

  always_comb begin
    next_line_tx_data = line_tx_data;
    next_line_tx_valid = line_tx_valid;
    next_line_tx_err = line_tx_err;
    if (tx_rise) begin
      next_line_tx_valid = tx_en_s;
      next_line_tx_err = 1'b0;
      next_line_tx_data = 5'h00;
      if (tx_en_s) begin
        if (rmii_s) begin
          next_line_tx_data = {1'b0, txd_s & `PMRCP_RMII_DATA_MASK};
        end else if (bypass_enc) begin
          next_line_tx_data = {tx_er_s, txd_s};
        end else if (tx_er_s) begin
          next_line_tx_data = `PMRCP_TX_ERR_SYM;
          next_line_tx_err = 1'b1;
        end else begin
          next_line_tx_data = {1'b0, txd_s};
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      clk_q <= 1'b0;
      line_tx_data <= 5'h00;
      line_tx_valid <= 1'b0;
      line_tx_err <= 1'b0;
    end else begin
      clk_q <= next_clk_q;
      line_tx_data <= next_line_tx_data;
      line_tx_valid <= next_line_tx_valid;
      line_tx_err <= next_line_tx_err;
    end
  end

  // ==========================================
  // Receive path
  logic fifo_valid;
  logic [`PMRCP_FIFO_WIDTH-1:0] fifo_data;
  logic [3:0] next_rxd;
  logic next_rx_dv, next_rx_er, next_crs, next_col;

  pmrcp_fifo #(
    .WIDTH(`PMRCP_FIFO_WIDTH),
    .DEPTH(`PMRCP_FIFO_DEPTH)
  ) u_rx_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_valid(line_rx_valid),
    .in_ready(line_rx_ready),
    .in_data({line_rx_code_err, line_rx_fifth, line_rx_data}),
    .out_valid(fifo_valid),
    .out_ready(rx_fall),
    .out_data(fifo_data)
  );

  always_comb begin
    next_rxd = rxd;
    next_rx_dv = rx_dv;
    next_rx_er = rx_er;
    next_crs = crs;
    next_col = line_tx_valid && crs;
    if (rx_fall) begin
      next_crs = line_rx_carrier;
      next_rx_dv = fifo_valid && !rmii_s;
      next_rxd = 4'h0;
      next_rx_er = 1'b0;
      if (fifo_valid) begin
        next_rxd = rmii_s ? (fifo_data[3:0] & `PMRCP_RMII_DATA_MASK) : fifo_data[3:0];
        next_rx_er = (bypass_dec && !rmii_s) ? fifo_data[`PMRCP_FIFO_FIFTH_BIT] : fifo_data[`PMRCP_FIFO_ERR_BIT];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rxd <= 4'h0;
      rx_dv <= 1'b0;
      rx_er <= 1'b0;
      crs <= 1'b0;
      col <= 1'b0;
    end else begin
      rxd <= next_rxd;
      rx_dv <= next_rx_dv;
      rx_er <= next_rx_er;
      crs <= next_crs;
      col <= next_col;
    end
  end

  // ==========================================
  // Management frame and interrupt
  pmrcp_pkg::pmrcp_mstate_t mstate, next_mstate;
  logic [5:0] cnt, next_cnt;
  logic [1:0] op_sh, next_op_sh;
  logic [4:0] phy_sh, next_phy_sh, reg_sh, next_reg_sh, my_addr, next_my_addr;
  logic [15:0] snap, next_snap, latch, next_latch, mon_q, clr_mask, latch_at_read, next_latch_at_read;
  logic mdc_q, mdc_rise, hit, next_hit, next_mdio_out, next_mdio_oe;

  always_comb begin
    mdc_rise = mdc_s && !mdc_q;
    next_mstate = mstate;
    next_cnt = cnt;
    next_op_sh = op_sh;
    next_phy_sh = phy_sh;
    next_reg_sh = reg_sh;
    next_snap = snap;
    next_hit = hit;
    next_mdio_out = mdio_out;
    next_mdio_oe = mdio_oe;
    next_my_addr = my_addr;
    next_latch_at_read = latch_at_read;
    clr_mask = 16'h0000;
    if (mdc_rise) begin
      next_cnt = 6'(cnt + 1'b1);
      case (mstate)
        pmrcp_pkg::M_IDLE: begin
          if (mdio_s) begin
            next_cnt = (cnt == `PMRCP_PREAMBLE_LEN) ? cnt : 6'(cnt + 1'b1);
          end else begin
            next_cnt = 6'h00;
            if (cnt == `PMRCP_PREAMBLE_LEN) begin
              next_mstate = pmrcp_pkg::M_START;
            end
          end
        end
        pmrcp_pkg::M_START: begin
          next_cnt = 6'h00;
          next_mstate = mdio_s ? pmrcp_pkg::M_OP : pmrcp_pkg::M_IDLE;
        end
        pmrcp_pkg::M_OP: begin
          next_op_sh = {op_sh[0], mdio_s};
          if (next_cnt == `PMRCP_OP_LEN) begin
            next_cnt = 6'h00;
            next_mstate = pmrcp_pkg::M_PHY;
          end
        end
        pmrcp_pkg::M_PHY: begin
          next_phy_sh = {phy_sh[3:0], mdio_s};
          if (next_cnt == `PMRCP_FIELD_LEN) begin
            next_cnt = 6'h00;
            next_mstate = pmrcp_pkg::M_REG;
          end
        end
        pmrcp_pkg::M_REG: begin
          next_reg_sh = {reg_sh[3:0], mdio_s};
          if (next_cnt == `PMRCP_FIELD_LEN) begin
            next_cnt = 6'h00;
            next_mstate = pmrcp_pkg::M_TA;
            next_hit = (op_sh == `PMRCP_OP_READ) && (phy_sh == my_addr) && (next_reg_sh == `PMRCP_IRQ_REG_ADDR);
            next_snap = latch;
            next_latch_at_read = latch;
          end
        end
        pmrcp_pkg::M_TA: begin
          if (cnt == 6'h00) begin
            next_mdio_oe = hit;
            next_mdio_out = 1'b0;
          end else begin
            next_cnt = 6'h00;
            next_mstate = pmrcp_pkg::M_DATA;
            next_mdio_out = snap[15];
            next_snap = {snap[14:0], 1'b0};
          end
        end
        pmrcp_pkg::M_DATA: begin
          next_mdio_out = snap[15];
          next_snap = {snap[14:0], 1'b0};
          if (next_cnt == `PMRCP_DATA_LEN) begin
            next_cnt = 6'h00;
            next_mstate = pmrcp_pkg::M_IDLE;
            next_mdio_oe = 1'b0;
            next_mdio_out = 1'b0;
            next_hit = 1'b0;
            clr_mask = hit ? latch_at_read : 16'h0000;
          end
        end
        default: begin
          next_cnt = 6'h00;
          next_mstate = pmrcp_pkg::M_IDLE;
        end
      endcase
    end
    next_latch = (latch & ~clr_mask) | (monitor_bits ^ mon_q);
    mgmt_irq_n = 1'b0;
    mgmt_irq_oe = (latch != 16'h0000);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mstate <= pmrcp_pkg::M_IDLE;
      cnt <= 6'h00;
      op_sh <= 2'h0;
      phy_sh <= 5'h00;
      reg_sh <= 5'h00;
      snap <= 16'h0000;
      latch <= 16'h0000;
      latch_at_read <= 16'h0000;
      hit <= 1'b0;
      mdc_q <= 1'b0;
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0;
      mon_q <= monitor_bits;
      my_addr <= {strap_s, CHAN};
    end else begin
      mstate <= next_mstate;
      cnt <= next_cnt;
      op_sh <= next_op_sh;
      phy_sh <= next_phy_sh;
      reg_sh <= next_reg_sh;
      snap <= next_snap;
      latch <= next_latch;
      latch_at_read <= next_latch_at_read;
      hit <= next_hit;
      mdc_q <= mdc_s;
      mdio_out <= next_mdio_out;
      mdio_oe <= next_mdio_oe;
      mon_q <= monitor_bits;
      my_addr <= next_my_addr;
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence tx_err_take;
    tx_rise && tx_en_s && tx_er_s && !rmii_s && !bypass_enc;
  endsequence
  sequence ta_drive;
    $rose(mdio_oe) ##0 !mdio_out;
  endsequence

  tx_ignore_a: assert property (tx_rise && !tx_en_s |=> !line_tx_valid && !line_tx_err) else $error("tx taken without enable");
  tx_hold_a: assert property (!tx_rise |=> $stable(line_tx_data)) else $error("tx data moved off edge");
  tx_rmii_a: assert property (tx_rise && tx_en_s && rmii_s |=> line_tx_data[4:2] == 3'h0) else $error("rmii tx too wide");
  tx_error_a: assert property (tx_err_take |=> line_tx_err && line_tx_data == `PMRCP_TX_ERR_SYM) else $error("no error symbol");
  tx_fifth_a: assert property (tx_rise && tx_en_s && bypass_enc && !rmii_s |=> line_tx_data[4] == $past(tx_er_s) && !line_tx_err) else $error("fifth bit lost");
  rx_stable_a: assert property (!rx_fall |=> $stable({rxd, rx_dv, rx_er, crs})) else $error("rx moved off falling edge");
  rx_crs_a: assert property (rx_fall |=> crs == $past(line_rx_carrier)) else $error("carrier not followed");
  rx_dv_a: assert property (rx_fall && rmii_s |=> !rx_dv) else $error("rx valid used in rmii");
  rx_data_a: assert property (rx_fall && fifo_valid && !rmii_s |=> rx_dv && rxd == $past(fifo_data[3:0])) else $error("rx nibble wrong");
  col_on_a: assert property (line_tx_valid && crs |=> col) else $error("collision missed");
  mdio_edge_a: assert property (!mdc_rise |=> $stable(mdio_out) && $stable(mdio_oe)) else $error("mdio moved off mdc rise");
  ta_zero_a: assert property ($rose(mdio_oe) |-> ta_drive ##0 $past(hit)) else $error("bad turnaround");
  irq_set_a: assert property (monitor_bits != mon_q |=> mgmt_irq_oe) else $error("change not flagged");
  irq_hold_a: assert property (mgmt_irq_oe && !(mdc_rise && mstate == pmrcp_pkg::M_DATA) |=> mgmt_irq_oe) else $error("irq dropped early");
endmodule

// File: tb/pmrcp_mac_model.sv
// MAC controller and management station facing one PHY channel.
// Assumes mclk from the bench and a pull-up on the management data wire.
`timescale 1ns/1ns
module pmrcp_mac_model (
  input wire logic mclk,
  input wire logic ref_clk_in,
  output logic tx_en,
  output logic [3:0] txd,
  output logic tx_er,
  output logic mdc,
  output logic mdio_in,
  input wire logic mdio_out,
  input wire logic mdio_oe
);
  logic sta_oe;
  logic sta_bit;

  assign mdio_in = sta_oe ? sta_bit : (mdio_oe ? mdio_out : 1'b1);

  initial begin
    tx_en = 1'b0;
    txd = 4'h0;
    tx_er = 1'b0;
    mdc = 1'b0;
    sta_oe = 1'b0;
    sta_bit = 1'b1;
  end

  // ==========================================
  // Transmit side
  // launch after reference fall
  task automatic tx_nib(input logic en, input logic [3:0] d, input logic er);
    @(negedge ref_clk_in);
    @(posedge mclk);
    #2;
    tx_en = en;
    txd = d;
    tx_er = er;
  endtask

  // ==========================================
  // Management station
  // sample just before each rise
  task automatic mdc_bit(input logic oe, input logic b, output logic s);
    sta_oe = oe;
    sta_bit = b;
    repeat (4) @(posedge mclk);
    #2;
    s = mdio_in;
    mdc = 1'b1;
    repeat (4) @(posedge mclk);
    #2;
    mdc = 1'b0;
  endtask

  task automatic mgmt_read(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
      output logic [15:0] d, output logic drove);
    logic [13:0] hdr;
    logic s;
    hdr = {2'b01, op, pa, ra};
    drove = 1'b0;
    for (int i = 0; i < 32; i++) mdc_bit(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) mdc_bit(1'b1, hdr[i], s);
    for (int i = 0; i < 18; i++) begin
      mdc_bit(1'b0, 1'b0, s);
      drove = drove | mdio_oe;
      if (i >= 2) d[17-i] = s;
    end
  endtask
endmodule

// File: tb/tb.sv
// Self-checking bench for one PHY channel controller port.
// Assumes the port carries its own assertions; strap pins tied to 3'h5.
`timescale 1ns/1ns
`include "pmrcp_defines.svh"
module tb;
  logic mclk, rst, ref_clk_in, rmii_sel, bypass_enc, bypass_dec, tx_clk, tx_en, tx_er, rx_clk;
  logic rx_dv, rx_er, crs, col, line_tx_valid, line_tx_err, line_rx_valid, line_rx_ready;
  logic line_rx_fifth, line_rx_code_err, line_rx_carrier, mdc, mdio_in, mdio_out, mdio_oe;
  logic mgmt_irq_n, mgmt_irq_oe, saw_full, drv;
  logic [3:0] txd, rxd, line_rx_data;
  logic [4:0] line_tx_data;
  logic [15:0] monitor_bits, rd;
  logic [6:0] tx_q[$];
  logic [5:0] rx_q[$];
  int n_mismatch, samples_checked, seed;

  pmrcp_mac_model u_mac (.mclk, .ref_clk_in, .tx_en, .txd, .tx_er, .mdc, .mdio_in, .mdio_out, .mdio_oe);

  pmrcp_port #(.CHAN(2'h2)) u_dut (.mclk, .rst, .ref_clk_in, .rmii_sel, .bypass_enc, .bypass_dec,
    .tx_clk, .tx_en, .txd, .tx_er, .rx_clk, .rxd, .rx_dv, .rx_er, .crs, .col, .line_tx_data,
    .line_tx_valid, .line_tx_err, .line_rx_valid, .line_rx_ready, .line_rx_data, .line_rx_fifth,
    .line_rx_code_err, .line_rx_carrier, .mdc, .mdio_in, .mdio_out, .mdio_oe,
    .phy_addr_strap_hi(3'h5), .monitor_bits, .mgmt_irq_n, .mgmt_irq_oe);

  // ==========================================
  // Clocks
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  initial begin
    ref_clk_in = 1'b0;
    #7;
    forever #80 ref_clk_in = ~ref_clk_in;
  end

  // ==========================================
  // Checking and verdict
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge mclk);
    n_mismatch++;
    print_verdict();
  end

  // Takes the oldest note whenever a symbol or receive nibble appears
  initial begin
    logic pt, pr;
    pt = 1'b0;
    pr = 1'b0;
    forever begin
      @(posedge mclk);
      #2;
      if (tx_clk === 1'b1 && pt === 1'b0 && tx_q.size() > 0) begin
        check("line_tx", {line_tx_valid, line_tx_err, line_tx_data}, tx_q.pop_front());
      end
      if (rx_clk === 1'b0 && pr === 1'b1 && (rx_dv === 1'b1 || rxd[1:0] !== 2'b00) && rx_q.size() > 0) begin
        check("rx_out", {rx_dv, rx_er, rxd}, rx_q.pop_front());
      end
      pt = tx_clk;
      pr = rx_clk;
    end
  end

  // ==========================================
  // Drivers
  task automatic tx_one(input logic en, input logic [3:0] d, input logic er);
    logic [6:0] e;
    u_mac.tx_nib(en, d, er);
    if (!en) e = 7'h00;
    else if (rmii_sel) e = {2'b10, 3'b000, d[1:0]};
    else if (bypass_enc) e = {2'b10, er, d};
    else if (er) e = {2'b11, `PMRCP_TX_ERR_SYM};
    else e = {2'b10, 1'b0, d};
    tx_q.push_back(e);
  endtask

  task automatic rx_push(input logic [3:0] d, input logic f, input logic ce);
    logic r;
    line_rx_valid = 1'b1;
    line_rx_data = d;
    line_rx_fifth = f;
    line_rx_code_err = ce;
    rx_q.push_back(rmii_sel ? {1'b0, ce, 2'b00, d[1:0]} : {1'b1, bypass_dec ? f : ce, d});
    r = 1'b0;
    for (int i = 0; i < 40 && r !== 1'b1; i++) begin
      @(negedge mclk);
      r = line_rx_ready;
      if (r !== 1'b1) saw_full = 1'b1;
      @(posedge mclk);
    end
    if (r !== 1'b1) begin
      n_mismatch++;
      print_verdict();
    end
    #2;
  endtask

  task automatic mg(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
      input logic ed, input logic [15:0] ev, input logic ei);
    u_mac.mgmt_read(op, pa, ra, rd, drv);
    repeat (4) @(posedge mclk);
    #2;
    check("mdio_drive", drv, ed);
    check("mdio_data", rd, ev);
    check("irq", mgmt_irq_oe, ei);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    int m, j;
    logic [3:0] d;
    rst = 1'b1;
    rmii_sel = 1'b0;
    bypass_enc = 1'b0;
    bypass_dec = 1'b0;
    line_rx_valid = 1'b0;
    line_rx_data = 4'h0;
    line_rx_fifth = 1'b0;
    line_rx_code_err = 1'b0;
    line_rx_carrier = 1'b0;
    monitor_bits = 16'h0000;
    saw_full = 1'b0;
    n_mismatch = 0;
    samples_checked = 0;
    seed = 32'h87734eec;
    repeat (8) @(posedge mclk);
    #2;
    rst = 1'b0;
    // Let the reference edge seen at reset release pass before any note is queued
    repeat (4) @(posedge mclk);
    for (m = 0; m < 4; m++) begin
      rmii_sel = m[1];
      bypass_enc = m[0];
      tx_one(1'b0, 4'hF, 1'b1);
      tx_one(1'b0, 4'hF, 1'b1);
      for (j = 0; j < 8; j++) tx_one(j != 3, 4'($random(seed)), 1'($random(seed)));
      tx_one(1'b0, 4'h0, 1'b0);
    end
    line_rx_carrier = 1'b1;
    for (m = 0; m < 3; m++) begin
      rmii_sel = (m == 2);
      bypass_dec = (m == 1);
      repeat (24) @(posedge mclk);
      #2;
      for (j = 0; j < 8; j++) begin
        d = 4'($random(seed));
        rx_push(d | {3'b000, rmii_sel}, 1'($random(seed)), 1'($random(seed)));
      end
      line_rx_valid = 1'b0;
      for (j = 0; j < 200 && rx_q.size() > 0; j++) @(posedge mclk);
      #2;
      check("rx_left", rx_q.size(), 16'h0000);
      check("crs_on", crs, 1'b1);
    end
    rmii_sel = 1'b0;
    repeat (20) @(posedge mclk);
    #2;
    check("rx_idle", {rx_dv, rx_er, rxd}, 6'h00);
    check("buf_full", saw_full, 1'b1);
    for (j = 0; j < 6; j++) begin
      if (j == 3) line_rx_carrier = 1'b0;
      tx_one(1'b1, 4'($random(seed)), 1'b0);
      if (j == 2) check("col_on", col, 1'b1);
    end
    check("crs_off", crs, 1'b0);
    check("col_off", col, 1'b0);
    tx_one(1'b0, 4'h0, 1'b0);
    check("irq_idle", mgmt_irq_oe, 1'b0);
    monitor_bits = 16'h0005;
    repeat (3) @(posedge mclk);
    #2;
    check("irq_set", {mgmt_irq_n, mgmt_irq_oe}, 2'b01);
    mg(2'h2, 5'h15, 5'h11, 1'b0, 16'hFFFF, 1'b1);
    mg(2'h1, 5'h16, 5'h11, 1'b0, 16'hFFFF, 1'b1);
    mg(2'h2, 5'h16, 5'h10, 1'b0, 16'hFFFF, 1'b1);
    mg(2'h2, 5'h16, 5'h11, 1'b1, 16'h0005, 1'b0);
    monitor_bits = 16'h0004;
    repeat (3) @(posedge mclk);
    #2;
    check("irq_again", mgmt_irq_oe, 1'b1);
    mg(2'h2, 5'h16, 5'h11, 1'b1, 16'h0001, 1'b0);
    print_verdict();
  end
endmodule
